//--- tcr_top.sv
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tcr_defines.svh"

// Overview of operation
// [RULE_01] A watchdog power-up clear resets both timers' control and vector registers, and a compare register change in the same cycle cannot alter them.
// [RULE_02] That protection holds whether or not the timer is counting.
// [RULE_03] A full 16-bit write of a timer control register clears its vector register.
// [RULE_04] Software initialises each control register with a full word write after reset, writing zero for an unused timer.
// [RULE_05] The counter can count from an external timer clock or the auxiliary clock, both far slower than the main clock.
// [RULE_06] In compare mode a channel raises its compare interrupt when the counter equals its compare register.
// [RULE_07] A compare register advanced by one before the next increment raises the interrupt at that increment.
// [RULE_08] Software may park a channel in capture mode while advancing its compare register and then return it to compare mode.
module tcr_top
  import tcr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Timer clock pins
  input wire logic timer1ExtClock,
  input wire logic timer2ExternalClock,
  input wire logic auxClock,
  // Watchdog, same clock domain
  input wire logic watchdogPowerUpClear,
  // Interrupt
  output logic irq
);

  tcr_top_type s_r;
  tcr_top_type s_nxt;
  logic acc;
  logic [`TCR_NTMR-1:0][15:0] cntArr;
  logic [`TCR_NTMR-1:0][`TCR_NCH-1:0] matchArr;
  logic [`TCR_NTMR-1:0] extPin;

  tcr_timer_if tif[`TCR_NTMR] ();

  assign extPin = {timer2ExternalClock, timer1ExtClock};
  assign acc = cyc_i & stb_i & ~s_r.ack;

  for (genvar g = 0; g < `TCR_NTMR; g++) begin : gTmr
    assign tif[g].run = s_r.ctrl[g][`TCR_CTRL_RUN];
    assign tif[g].src = s_r.ctrl[g][`TCR_CTRL_SRC];
    assign tif[g].clr = s_r.clrPend[g];
    assign tif[g].power_up_clear = watchdogPowerUpClear;
    assign tif[g].extLvl = s_r.extSync[g][1];
    assign tif[g].auxLvl = s_r.auxSync[1];
    assign tif[g].cap = s_r.ctrl[g][`TCR_CTRL_CAP+:`TCR_NCH];
    assign tif[g].cmp = s_r.cmp[g];
    assign cntArr[g] = tif[g].count;
    assign matchArr[g] = tif[g].match;

    tcr_counter uCtr (
      .mclk(mclk),
      .rst(rst),
      .port(tif[g])
    );
  end

  function automatic logic [15:0] mergeBytes(input logic [15:0] old,
      input logic [15:0] wd, input logic [1:0] sel);
    logic [15:0] v;
    v = old;
    if (sel[0]) begin
      v[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction

  // Lowest channel has the highest priority
  function automatic logic [15:0] vecOf(input logic [`TCR_NCH-1:0] f);
    logic [15:0] v;
    v = `TCR_VEC_NONE;
    for (int i = `TCR_NCH - 1; i >= 0; i--) begin
      if (f[i]) begin
        v = 16'(2 * (i + 1));
      end
    end
    return v;
  endfunction

  always_comb begin
    logic hit;
    logic [2:0] idx;
    logic [15:0] rd;
    hit = 1'b0;
    idx = adr_i[4:2];
    rd = 16'h0000;
    s_nxt = s_r;
    s_nxt.ack = acc;
    s_nxt.dat = 32'h0000_0000;
    s_nxt.clrPend = '0;
    for (int t = 0; t < `TCR_NTMR; t++) begin
      s_nxt.extSync[t] = {s_r.extSync[t][0], extPin[t]};
    end
    s_nxt.auxSync = {s_r.auxSync[0], auxClock};
    for (int t = 0; t < `TCR_NTMR; t++) begin
      hit = acc && adr_i[7:6] == 2'b00
        && adr_i[`TCR_TMR_SEL_BIT] == 1'(t);
      if (hit && we_i) begin
        if (idx == `TCR_REG_CTRL) begin
          s_nxt.ctrl[t] = mergeBytes(s_r.ctrl[t], dat_i[15:0], sel_i[1:0]);
          s_nxt.ctrl[t][`TCR_CTRL_CLR] = 1'b0;
          s_nxt.clrPend[t] = sel_i[0] & dat_i[`TCR_CTRL_CLR];
          if (sel_i[1:0] == 2'b11) begin
            s_nxt.flag[t] = '0; // RULE_03
          end
        end
        for (int ch = 0; ch < `TCR_NCH; ch++) begin
          if (idx == 3'(`TCR_REG_CMP0 + ch)) begin
            s_nxt.cmp[t][ch] = mergeBytes(s_r.cmp[t][ch], dat_i[15:0],
                                          sel_i[1:0]);
          end
        end
      end
      if (hit && !we_i) begin
        if (idx == `TCR_REG_CTRL) begin
          rd = s_r.ctrl[t];
        end else if (idx == `TCR_REG_VEC) begin
          rd = s_r.vec[t];
          // Reading the vector acknowledges the source it names
          for (int ch = 0; ch < `TCR_NCH; ch++) begin
            if (s_r.vec[t] == 16'(2 * (ch + 1))) begin
              s_nxt.flag[t][ch] = 1'b0;
            end
          end
        end else if (idx == `TCR_REG_CNT) begin
          rd = cntArr[t];
        end
        for (int ch = 0; ch < `TCR_NCH; ch++) begin
          if (idx == 3'(`TCR_REG_CMP0 + ch)) begin
            rd = s_r.cmp[t][ch];
          end
        end
        s_nxt.dat = {16'h0000, rd};
      end
      // Set after clear, so an event in the clearing cycle survives
      s_nxt.flag[t] = s_nxt.flag[t] | matchArr[t]; // RULE_06
      s_nxt.vec[t] = vecOf(s_nxt.flag[t]);
    end
    if (acc && !we_i && adr_i == `TCR_OFF_ISTAT) begin
      s_nxt.dat = {{(32 - `TCR_NEV){1'b0}}, s_r.intStat};
      s_nxt.intStat = '0;
    end
    if (acc && !we_i && adr_i == `TCR_OFF_IMASK) begin
      s_nxt.dat = {{(32 - `TCR_NEV){1'b0}}, s_r.intMask};
    end
    if (acc && we_i && adr_i == `TCR_OFF_IMASK && sel_i[0]) begin
      s_nxt.intMask = dat_i[`TCR_NEV-1:0];
    end
    s_nxt.intStat = s_nxt.intStat | matchArr;
    if (watchdogPowerUpClear) begin
      // Clear wins over any timer register write or compare change this cycle (a mask write still lands),
      // running or not; compare registers keep their old value
      for (int t = 0; t < `TCR_NTMR; t++) begin
        s_nxt.ctrl[t] = `TCR_CTRL_RST; // RULE_01 RULE_02 RULE_04
        s_nxt.vec[t] = `TCR_VEC_NONE; // RULE_01 RULE_02
        s_nxt.flag[t] = '0;
        s_nxt.cmp[t] = s_r.cmp[t]; // RULE_01
        s_nxt.clrPend[t] = 1'b0;
      end
    end
    s_nxt.irq = |(s_nxt.intStat & s_nxt.intMask);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dat_o = s_r.dat;
  assign ack_o = s_r.ack;
  assign irq = s_r.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_puc_ctrl_vec: assert property ( // RULE_01
    watchdogPowerUpClear |=> s_r.ctrl[0] == 16'h0000
      && s_r.ctrl[1] == 16'h0000 && s_r.vec[0] == 16'h0000
      && s_r.vec[1] == 16'h0000)
    else $error("control or vector survived a power-up clear");
  a_puc_cmp_keep: assert property ( // RULE_01
    watchdogPowerUpClear |=> s_r.cmp == $past(s_r.cmp))
    else $error("compare register changed during a power-up clear");
  a_puc_running: assert property ( // RULE_02
    (watchdogPowerUpClear && s_r.ctrl[1][`TCR_CTRL_RUN])
      |=> s_r.flag[1] == '0 && !s_r.ctrl[1][`TCR_CTRL_RUN])
    else $error("running timer not cleared by power-up clear");
  a_full_wr_vec: assert property ( // RULE_03
    (acc && we_i && adr_i == 8'h20 && sel_i[1:0] == 2'b11
      && !watchdogPowerUpClear && matchArr[1] == '0)
      |=> s_r.vec[1] == 16'h0000)
    else $error("full control write left the vector set");
  a_match_vec: assert property ( // RULE_06
    (matchArr[1][0] && !watchdogPowerUpClear)
      |=> s_r.vec[1] == 16'h0002 && s_r.intStat[`TCR_NCH])
    else $error("compare match not shown in vector or status");
  a_ack_pulse: assert property (
    acc |=> ack_o ##1 !ack_o)
    else $error("bus answer not a single cycle");
  a_irq_level: assert property (
    irq == |(s_r.intStat & s_r.intMask))
    else $error("interrupt output disagrees with status and mask");
  a_stat_sticky: assert property (
    !(acc && !we_i && adr_i == `TCR_OFF_ISTAT)
      |=> (s_r.intStat & $past(s_r.intStat)) == $past(s_r.intStat))
    else $error("status bit lost without a read");

endmodule

`default_nettype wire

//--- tcr_defines.svh
`ifndef TCR_DEFINES_SVH
`define TCR_DEFINES_SVH

// Geometry
`define TCR_NTMR 2
`define TCR_NCH 2
`define TCR_NEV 4

// Byte offsets: timer 1 at 8'h00, timer 2 at 8'h20, word index in [4:2]
`define TCR_TMR_SEL_BIT 5
`define TCR_REG_CTRL 3'h0
`define TCR_REG_VEC 3'h1
`define TCR_REG_CNT 3'h2
`define TCR_REG_CMP0 3'h3
`define TCR_OFF_ISTAT 8'h40
`define TCR_OFF_IMASK 8'h44

// Control fields
`define TCR_CTRL_RUN 0
`define TCR_CTRL_SRC 1
`define TCR_CTRL_CLR 2
`define TCR_CTRL_CAP 8

// Reset values
`define TCR_CTRL_RST 16'h0000
`define TCR_VEC_NONE 16'h0000

`endif

//--- tcr_pkg.sv
`default_nettype none
`include "tcr_defines.svh"

package tcr_pkg;

  typedef struct packed {
    logic [15:0] count;
    logic [`TCR_NCH-1:0] match;
    logic extPrev;
    logic auxPrev;
  } tcr_ctr_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [`TCR_NEV-1:0] intStat;
    logic [`TCR_NEV-1:0] intMask;
    logic irq;
    logic [`TCR_NTMR-1:0][15:0] ctrl;
    logic [`TCR_NTMR-1:0][15:0] vec;
    logic [`TCR_NTMR-1:0][`TCR_NCH-1:0][15:0] cmp;
    logic [`TCR_NTMR-1:0][`TCR_NCH-1:0] flag;
    logic [`TCR_NTMR-1:0] clrPend;
    logic [`TCR_NTMR-1:0][1:0] extSync;
    logic [1:0] auxSync;
  } tcr_top_type;

endpackage

`default_nettype wire

//--- tcr_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcr_defines.svh"

interface tcr_timer_if;
  logic run;
  logic src;
  logic clr;
  logic power_up_clear;
  logic extLvl;
  logic auxLvl;
  logic [`TCR_NCH-1:0] cap;
  logic [`TCR_NCH-1:0][15:0] cmp;
  logic [15:0] count;
  logic [`TCR_NCH-1:0] match;

  modport ctr(input run, src, clr, power_up_clear, extLvl, auxLvl, cap, cmp,
              output count, match);
  modport ctl(output run, src, clr, power_up_clear, extLvl, auxLvl, cap, cmp,
              input count, match);
endinterface

`default_nettype wire

//--- tcr_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcr_defines.svh"

module tcr_counter
  import tcr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control side
  tcr_timer_if.ctr port
);

  tcr_ctr_type s_r;
  tcr_ctr_type s_nxt;
  logic srcEdge;
  logic tick;

  always_comb begin
    s_nxt = s_r;
    s_nxt.match = '0;
    s_nxt.extPrev = port.extLvl;
    s_nxt.auxPrev = port.auxLvl;
    // Slow timer clock seen as a rising edge of the synced level
    srcEdge = port.src ? (port.auxLvl & ~s_r.auxPrev)
                       : (port.extLvl & ~s_r.extPrev); // RULE_05
    tick = port.run & srcEdge;
    if (port.clr) begin
      s_nxt.count = 16'h0000;
    end else if (tick) begin
      s_nxt.count = s_r.count + 16'h0001; // RULE_05
      for (int ch = 0; ch < `TCR_NCH; ch++) begin
        // Compared at the increment against the live compare value, so
        // an advance made between increments is never missed
        if (!port.cap[ch] && s_nxt.count == port.cmp[ch]) begin // RULE_08
          s_nxt.match[ch] = 1'b1; // RULE_06 RULE_07
        end
      end
    end
    if (port.power_up_clear) begin
      s_nxt.count = 16'h0000;
      s_nxt.match = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign port.count = s_r.count;
  assign port.match = s_r.match;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_count_step: assert property ( // RULE_05
    (tick && !port.clr && !port.power_up_clear) |=>
      s_r.count == $past(s_r.count) + 16'h0001)
    else $error("counter did not step on a timer clock edge");
  a_count_hold: assert property ( // RULE_05
    (!tick && !port.clr && !port.power_up_clear) |=> $stable(s_r.count))
    else $error("counter moved without a timer clock edge");
  a_match_raise: assert property ( // RULE_06
    (tick && !port.clr && !port.power_up_clear && !port.cap[0]
      && s_r.count + 16'h0001 == port.cmp[0]) |=> s_r.match[0])
    else $error("compare equality raised no match");
  a_adv_match: assert property ( // RULE_07
    (tick && !port.clr && !port.power_up_clear && !port.cap[0]
      && port.cmp[0] == s_r.count + 16'h0001
      && $past(port.cmp[0], 8) == s_r.count) |=> s_r.match[0])
    else $error("match after a compare advance was lost");

endmodule

`default_nettype wire

//--- tcr_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_top_tb_top;
  import tcr_pkg::*;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic wdPuc = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic [2:0] pins = 3'h0;
  logic [15:0] q;
  int mismatches = 0;
  int n_checks = 0;

  always #2.5 mclk = ~mclk;

  tcr_top i_dut (
    .mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .timer1ExtClock(pins[0]), .timer2ExternalClock(pins[1]),
    .auxClock(pins[2]), .watchdogPowerUpClear(wdPuc), .irq(irq)
  );

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Called just after an edge; optional power-up clear rides on the request
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] d, input logic [1:0] s,
                    input logic p);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    sel <= {2'h0, s};
    wdPuc <= p;
    for (int n = 0; n < 20; n++) begin
      @(posedge mclk);
      wdPuc <= 1'h0;
      if (ack === 1'h1) begin
        q = rdat[15:0];
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
        @(posedge mclk);
        return;
      end
    end
    mismatches++;
    $display("wrong value at %0t: bus never answered", $time);
    tally_and_finish();
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp,
                    input string msg);
    wb(1'h0, a, 16'h0000, 2'h3, 1'h0);
    chk(q, exp, msg);
  endtask

  // Slow count clock: high for three mclk, low for five mclk, plus sync settle
  task automatic pulse(input int idx);
    pins[idx] <= 1'h1;
    repeat (3) @(posedge mclk);
    pins[idx] <= 1'h0;
    repeat (5) @(posedge mclk);
  endtask

  task automatic t_reset;
    rd(8'h00, 16'h0000, "t1 ctrl reset");
    rd(8'h24, 16'h0000, "t2 vec reset");
    rd(8'h44, 16'h0000, "mask reset");
    wb(1'h1, 8'h60, 16'hFFFF, 2'h3, 1'h0);
    rd(8'h60, 16'h0000, "unmapped");
    chk({15'h0, irq}, 16'h0000, "irq reset");
    $display("test reset done");
  endtask

  task automatic t_ext1;
    wb(1'h1, 8'h10, 16'h0001, 2'h3, 1'h0);
    wb(1'h1, 8'h00, 16'h0001, 2'h3, 1'h0);
    pulse(0);
    chk({15'h0, irq}, 16'h0000, "masked irq");
    rd(8'h04, 16'h0004, "t1 vec ch1");
    rd(8'h40, 16'h0002, "status t1 ch1");
    rd(8'h40, 16'h0000, "status cleared");
    $display("test ext1 done");
  endtask

  task automatic t_adv;
    wb(1'h1, 8'h44, 16'h000F, 2'h3, 1'h0);
    wb(1'h1, 8'h2C, 16'h0002, 2'h3, 1'h0);
    wb(1'h1, 8'h20, 16'h0003, 2'h3, 1'h0);
    pulse(2);
    pulse(2);
    chk({15'h0, irq}, 16'h0001, "irq on match");
    rd(8'h28, 16'h0002, "t2 count");
    rd(8'h40, 16'h0004, "status t2 ch0");
    chk({15'h0, irq}, 16'h0000, "irq after clear");
    wb(1'h1, 8'h2C, 16'h0003, 2'h3, 1'h0);
    pulse(2);
    rd(8'h40, 16'h0004, "advanced match");
    rd(8'h24, 16'h0002, "t2 vec ch0");
    rd(8'h24, 16'h0000, "vec read clears");
    wb(1'h1, 8'h20, 16'h0103, 2'h3, 1'h0);
    wb(1'h1, 8'h2C, 16'h0004, 2'h3, 1'h0);
    pulse(2);
    rd(8'h28, 16'h0004, "t2 count in capture");
    rd(8'h40, 16'h0000, "capture mode no match");
    wb(1'h1, 8'h2C, 16'h0005, 2'h3, 1'h0);
    wb(1'h1, 8'h20, 16'h0003, 2'h3, 1'h0);
    pulse(2);
    rd(8'h40, 16'h0004, "match after capture park");
    rd(8'h24, 16'h0002, "vec after capture park");
    $display("test advance done");
  endtask

  task automatic t_vec;
    wb(1'h1, 8'h20, 16'h0005, 2'h3, 1'h0);
    rd(8'h28, 16'h0000, "count clear bit");
    rd(8'h20, 16'h0001, "clear bit reads zero");
    wb(1'h1, 8'h2C, 16'h0001, 2'h3, 1'h0);
    wb(1'h1, 8'h30, 16'h0001, 2'h3, 1'h0);
    pulse(1);
    rd(8'h40, 16'h000C, "both t2 channels");
    rd(8'h24, 16'h0002, "lowest first");
    wb(1'h1, 8'h20, 16'h0001, 2'h3, 1'h0);
    rd(8'h24, 16'h0000, "full write clears vec");
    $display("test vector done");
  endtask

  task automatic t_puc;
    wb(1'h1, 8'h00, 16'h0100, 2'h3, 1'h0);
    wb(1'h1, 8'h2C, 16'h0002, 2'h3, 1'h0);
    pulse(1);
    rd(8'h40, 16'h0004, "t2 match before clear");
    wb(1'h1, 8'h2C, 16'h0006, 2'h3, 1'h1);
    rd(8'h00, 16'h0000, "stopped t1 ctrl");
    rd(8'h20, 16'h0000, "running t2 ctrl");
    rd(8'h24, 16'h0000, "t2 vec");
    rd(8'h2C, 16'h0002, "dropped compare write");
    rd(8'h28, 16'h0000, "t2 count cleared");
    $display("test power-up clear done");
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    t_reset();
    wb(1'h1, 8'h00, 16'h0000, 2'h3, 1'h0);
    wb(1'h1, 8'h20, 16'h0000, 2'h3, 1'h0);
    t_ext1();
    t_adv();
    t_vec();
    t_puc();
    tally_and_finish();
  end
endmodule
`default_nettype wire
